// ### rtl/fsv_pkg.sv
// fsv_pkg: shared constants for the frame sync validator
// assumes a 250 MHz system clock; pulses are one-cycle strobes
package fsv_pkg;
	// clock period in picoseconds
	localparam int unsigned CLK_PERIOD_PS    = 4000;
	// sync gate delay range, microseconds
	localparam int unsigned GATE_DLY_MIN_US  = 4;
	localparam int unsigned GATE_DLY_MAX_US  = 25;
	// window close delay after frame sync, microseconds
	localparam int unsigned CLOSE_DLY_US     = 3;
	// cycle counts derived from the times
	localparam int unsigned GATE_DLY_MIN_CYC = (GATE_DLY_MIN_US * 1000000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int unsigned GATE_DLY_MAX_CYC = (GATE_DLY_MAX_US * 1000000) / CLK_PERIOD_PS;
	localparam int unsigned CLOSE_DLY_CYC    = (CLOSE_DLY_US * 1000000) / CLK_PERIOD_PS;
	// counter width for delay settings
	localparam int unsigned DLY_W            = 13;
	// reset values
	localparam logic        WIN_OPEN_RST     = 1'b1;
	localparam logic        STAGE_RST        = 1'b0;
	// sync gate states
	typedef enum logic [1:0] {
		FSV_IDLE  = 2'b00,
		FSV_DELAY = 2'b01,
		FSV_CLOSE = 2'b11
	} fsv_state_e;
endpackage

// ### rtl/fsv_delay_gate.sv
// fsv_delay_gate: keyed window gate with delayed frame sync output
// assumes sync_in and key_in are one-cycle strobes; dly_cyc is held steady
`timescale 1ns/1ns
module fsv_delay_gate
	import fsv_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// delay setting
	input  wire logic [DLY_W-1:0] dly_cyc,
	// pulses in
	input  wire logic             key_in,
	input  wire logic             sync_in,
	// outputs
	output logic                  frame_sync,
	output logic                  win_open
);
	fsv_state_e       state_q, state_d;
	logic [DLY_W-1:0] cnt_q, cnt_d;
	logic             win_q, win_d;
	logic             out_q, out_d;

	// next-state logic
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		win_d   = win_q;
		out_d   = 1'b0;
		// [RL11] key opens window
		if (key_in) begin
			win_d = 1'b1;
		end
		unique case (state_q)
			FSV_IDLE: begin
				// [RL12] start sync delay
				if (sync_in) begin
					state_d = FSV_DELAY;
					cnt_d   = dly_cyc;
				end
			end
			FSV_DELAY: begin
				if (cnt_q <= DLY_W'(1)) begin
					// [RL13] emit only if open
					if (win_q) begin
						out_d   = 1'b1;
						state_d = FSV_CLOSE;
						cnt_d   = DLY_W'(CLOSE_DLY_CYC);
					end else begin
						state_d = FSV_IDLE;
					end
				end else begin
					cnt_d = cnt_q - DLY_W'(1);
				end
			end
			FSV_CLOSE: begin
				// [RL14] close window later
				if (cnt_q <= DLY_W'(1)) begin
					state_d = FSV_IDLE;
					// [RL15] stays open otherwise
					if (!key_in) begin
						win_d = 1'b0;
					end
				end else begin
					cnt_d = cnt_q - DLY_W'(1);
				end
			end
			default: begin
				state_d = FSV_IDLE;
			end
		endcase
	end

	// [RL19] window starts open
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= FSV_IDLE;
			cnt_q   <= '0;
			win_q   <= WIN_OPEN_RST;
			out_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			win_q   <= win_d;
			out_q   <= out_d;
		end
	end

	assign frame_sync = out_q;
	assign win_open   = win_q;
endmodule

// ### rtl/fsv_top.sv
// fsv_top: frame sync validator; detector, keyed selector and sync gate
// assumes all inputs synchronous one-cycle strobes or levels of clk
//
// Operation
// [RL1] detector has a buffer stage and a clocked storage stage
// [RL2] separator reset pulse clears buffer before sync of the period
// [RL3] storage takes buffer on bit clock rise: sync delayed one bit
// [RL4] no buffered sync loads storage with absence
// [RL5] term one: buffer and storage both show sync
// [RL6] term two: direct and stored eight-bit syncs both asserted
// [RL7] OR of terms, rising edge gives one detector pulse
// [RL8] selector passes detector pulses only while keying is high
// [RL9] passed pulses go out as subcommutated sync
// [RL10] composite sync on gated subcom sync or main frame sync
// [RL11] keying pulse opens the sync gate window
// [RL12] sync rise starts a 4 to 25 us adjustable delay
// [RL13] delayed sync leaves only if window open
// [RL14] about 3 us after frame sync the window closes
// [RL15] without sync the window stays open indefinitely
// [RL16] separator gives sync in each bit with a missing data pulse
// [RL17] eight-bit register supplies direct and eight-bit-old sync
// [RL18] pulses are clock strobes, one-shots are cycle counters
// [RL19] reset: window open, both detector stages cleared
`timescale 1ns/1ns
module fsv_top
	import fsv_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// separator and bit clock
	input  wire logic             bit_clk,
	input  wire logic             sep_reset,
	input  wire logic             sep_sync,
	// eight-bit register
	input  wire logic             sr_direct,
	input  wire logic             sr_stored,
	// selector inputs
	input  wire logic             subcom_key,
	input  wire logic             main_sync,
	// sync gate inputs
	input  wire logic             gate_key,
	input  wire logic [DLY_W-1:0] gate_dly,
	// outputs
	output logic                  det_sync,
	output logic                  subcom_sync,
	output logic                  comp_sync,
	output logic                  frame_sync,
	output logic                  win_open
);
	logic buf_q, buf_d;
	logic sto_q, sto_d;
	logic clk_q, hit_q, hit;
	logic det_q, sub_q, comp_q;
	logic det_d, sub_d, comp_d;

	// rising edge of a level against its sample one clock earlier
	function automatic logic fsv_rise(input logic now_v, input logic last_v);
		return now_v & ~last_v;
	endfunction

	// buffer and storage stages
	always_comb begin
		buf_d = buf_q;
		sto_d = sto_q;
		// [RL2] reset first, sync wins
		if (sep_reset) begin
			buf_d = 1'b0;
		end
		// [RL1] buffer catches sync
		if (sep_sync) begin
			buf_d = 1'b1;
		end
		// [RL3] [RL4] storage on rise
		if (fsv_rise(bit_clk, clk_q)) begin
			sto_d = buf_q;
		end
	end

	// [RL5] [RL6] coincidence terms
	assign hit = (buf_q & sto_q) | (sr_direct & sr_stored);

	// detector, selector and composite pulses
	always_comb begin
		// [RL7] rising edge pulse
		det_d  = fsv_rise(hit, hit_q);
		// [RL8] [RL9] keyed pass
		sub_d  = det_d & subcom_key;
		// [RL10] composite or
		comp_d = sub_d | main_sync;
	end

	// [RL18] [RL19] registered strobes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			buf_q  <= STAGE_RST;
			sto_q  <= STAGE_RST;
			// edge samples follow their levels: no false edge after reset
			clk_q  <= bit_clk;
			hit_q  <= hit;
			det_q  <= 1'b0;
			sub_q  <= 1'b0;
			comp_q <= 1'b0;
		end else begin
			buf_q  <= buf_d;
			sto_q  <= sto_d;
			clk_q  <= bit_clk;
			hit_q  <= hit;
			det_q  <= det_d;
			sub_q  <= sub_d;
			comp_q <= comp_d;
		end
	end

	// sync gate fed by detector pulse
	fsv_delay_gate u_gate (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.dly_cyc    (gate_dly),
		.key_in     (gate_key),
		.sync_in    (det_q),
		.frame_sync (frame_sync),
		.win_open   (win_open)
	);

	assign det_sync    = det_q;
	assign subcom_sync = sub_q;
	assign comp_sync   = comp_q;
endmodule

// ### bench/fsv_partner.sv
// fsv_partner: bit clock and separator strobes
// miss from the bench marks absent data pulses
`timescale 1ns/1ns
module fsv_partner (
	// clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// absent data pulse marker
	input  wire logic miss,
	// separator and bit clock
	output logic      bit_clk,
	output logic      sep_reset,
	output logic      sep_sync
);
	logic [2:0] ph_q;
	// eight clocks per bit period
	always_ff @(posedge clk) ph_q <= sys_rst ? 3'h0 : ph_q + 3'h1;
	// reset strobe with the clock rise
	assign bit_clk   = ~ph_q[2];
	assign sep_reset = ph_q == 3'h0;
	assign sep_sync  = miss && ph_q == 3'h4;
endmodule

// ### bench/fsv_top_asserts.sv
// fsv_top_asserts: checker bound to fsv_top
// sees the top ports only, one clock domain
`timescale 1ns/1ns
module fsv_top_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// inputs of the block
	input wire logic sr_direct,
	input wire logic sr_stored,
	input wire logic subcom_key,
	input wire logic main_sync,
	input wire logic gate_key,
	// outputs of the block
	input wire logic det_sync,
	input wire logic subcom_sync,
	input wire logic comp_sync,
	input wire logic frame_sync,
	input wire logic win_open
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_det_once: assert property (det_sync |=> !det_sync) else $error("det long");
	a_sr_det: assert property ($rose(sr_direct && sr_stored) |-> ##[1:2] det_sync)
		else $error("no det");
	a_subcom_key: assert property (subcom_sync == (det_sync && $past(subcom_key)))
		else $error("subcom bad");
	a_comp_main: assert property (main_sync |=> comp_sync) else $error("no comp");
	a_win_rst: assert property ($fell(sys_rst) |-> win_open && !det_sync)
		else $error("reset bad");
	a_key_open: assert property (gate_key |=> win_open) else $error("not open");
	a_frame_open: assert property (frame_sync |-> win_open) else $error("closed");
	a_open_hold: assert property (frame_sync |=> win_open[*8]) else $error("early");
	a_closed_stay: assert property (!win_open && !gate_key |=> !win_open)
		else $error("opened");
	c_det: cover property (det_sync);
	c_sub: cover property (subcom_sync);
	c_frame: cover property (frame_sync);
endmodule
bind fsv_top fsv_top_asserts u_fsv_top_asserts (
	.clk         (clk),
	.sys_rst     (sys_rst),
	.sr_direct   (sr_direct),
	.sr_stored   (sr_stored),
	.subcom_key  (subcom_key),
	.main_sync   (main_sync),
	.gate_key    (gate_key),
	.det_sync    (det_sync),
	.subcom_sync (subcom_sync),
	.comp_sync   (comp_sync),
	.frame_sync  (frame_sync),
	.win_open    (win_open)
);

// ### bench/testbench.sv
// testbench: directed checks of fsv_top
// fsv_partner supplies the separator side
`timescale 1ns/1ns
module testbench;
	import fsv_pkg::*;
	logic clk = 0, sys_rst = 1, miss = 0, sr_direct = 0, sr_stored = 0;
	logic subcom_key = 0, main_sync = 0, gate_key = 0;
	logic bit_clk, sep_reset, sep_sync, det_sync, subcom_sync, comp_sync, frame_sync, win_open;
	// gate delay kept inside the adjustable span
	logic [DLY_W-1:0] gate_dly = DLY_W'(GATE_DLY_MIN_CYC);
	// four-state counts, so an unknown pulse shows up
	logic [15:0] nd = 16'h0000, ns = 16'h0000, nc = 16'h0000, nf = 16'h0000;
	logic win_prev = 1'h1;
	int errors = 0, samples_checked = 0, n_cyc = 0, t_det = 0, t_frame = 0, t_shut = 0;
	fsv_partner u_fsv_partner (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.miss      (miss),
		.bit_clk   (bit_clk),
		.sep_reset (sep_reset),
		.sep_sync  (sep_sync)
	);
	fsv_top u_fsv_top (
		.clk         (clk),
		.sys_rst     (sys_rst),
		.bit_clk     (bit_clk),
		.sep_reset   (sep_reset),
		.sep_sync    (sep_sync),
		.sr_direct   (sr_direct),
		.sr_stored   (sr_stored),
		.subcom_key  (subcom_key),
		.main_sync   (main_sync),
		.gate_key    (gate_key),
		.gate_dly    (gate_dly),
		.det_sync    (det_sync),
		.subcom_sync (subcom_sync),
		.comp_sync   (comp_sync),
		.frame_sync  (frame_sync),
		.win_open    (win_open)
	);
	initial forever #2 clk = ~clk;
	// pulse counters and cycle stamps of detector, frame and window close
	always @(posedge clk) begin
		n_cyc <= n_cyc + 1;
		nd <= nd + det_sync;
		ns <= ns + subcom_sync;
		nc <= nc + comp_sync;
		nf <= nf + frame_sync;
		if (det_sync) t_det <= n_cyc;
		if (frame_sync) t_frame <= n_cyc;
		if (win_prev && !win_open) t_shut <= n_cyc;
		win_prev <= win_open;
	end
	task chk(logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task cyc(int n); repeat (n) @(posedge clk); endtask
	task clr; #1 nd = 16'h0000; ns = 16'h0000; nc = 16'h0000; nf = 16'h0000; endtask
	task sr_pulse;
		@(posedge clk) {sr_direct, sr_stored} <= 2'h3;
		@(posedge clk) {sr_direct, sr_stored} <= 2'h0;
		cyc(40);
	endtask
	task t_onebit;
		clr; @(posedge clk) miss <= 1'h1; cyc(8); miss <= 1'h0; cyc(40);
		chk(nd, 16'h0);
		clr; @(posedge clk) miss <= 1'h1; cyc(16); miss <= 1'h0; cyc(40);
		chk(nd, 16'h1);
		chk(ns, 16'h0);
		cyc(GATE_DLY_MIN_CYC);
		chk(nf, 16'h1);
		$display("onebit done");
	endtask
	task t_eight(logic k);
		clr; @(posedge clk) subcom_key <= k; sr_pulse;
		chk(nd, 16'h1);
		chk(ns, 16'(k));
		chk(nc, 16'(k));
		$display("eight done");
	endtask
	task t_main;
		clr; @(posedge clk) main_sync <= 1'h1; @(posedge clk) main_sync <= 1'h0; cyc(4);
		chk(nc, 16'h1);
		$display("main done");
	endtask
	// window shut after the frame, a sync then is dropped, a key reopens
	task t_gate;
		clr; cyc(CLOSE_DLY_CYC);
		chk(win_open, 16'h0);
		sr_pulse; cyc(GATE_DLY_MIN_CYC);
		chk(nf, 16'h0);
		@(posedge clk) gate_key <= 1'h1; @(posedge clk) gate_key <= 1'h0; cyc(900);
		chk(win_open, 16'h1);
		$display("gate done");
	endtask
	// keyed sync at delay d: frame d+1 cycles after detector, shut later
	task t_delay(int d);
		clr; @(posedge clk) gate_dly <= DLY_W'(d);
		gate_key <= 1'h1;
		@(posedge clk) gate_key <= 1'h0;
		sr_pulse; cyc(d);
		chk(nf, 16'h1);
		chk(16'(t_frame - t_det), 16'(d + 1));
		cyc(CLOSE_DLY_CYC);
		chk(16'(t_shut - t_frame), 16'(CLOSE_DLY_CYC));
		chk(win_open, 16'h0);
		$display("delay done");
	endtask
	// reset in mid-run with the window shut
	task t_reset;
		@(posedge clk) sys_rst <= 1'h1; cyc(2); sys_rst <= 1'h0; cyc(2); #1;
		chk(win_open, 16'h1);
		$display("reset done");
	endtask
	task conclude;
		$display("checks=%0d errors=%0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		cyc(20); sys_rst <= 1'h0; cyc(2); #1;
		chk(win_open, 16'h1);
		t_onebit; t_eight(1'h1); t_eight(1'h0); t_main; t_gate;
		t_delay(GATE_DLY_MIN_CYC);
		t_delay(GATE_DLY_MAX_CYC);
		t_reset;
		conclude;
	end
	// watchdog: the run needs about 13000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		conclude;
	end
endmodule
